// ==== common/mrc_cfg.svh ====
// Purpose: Constants for the operating-mode register block.
// Assumes: Command pins sampled on sys_clk; 10 MHz clock.
// Notes:   Field positions are address-pin indices.
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH
`define MRC_CLK_NS       100
`define MRC_TMRD_NCK     4
`define MRC_TMOD_NCK     12
`define MRC_TMOD_NS      15
`define MRC_TMOD_CYC_NS  ((`MRC_TMOD_NS + `MRC_CLK_NS - 1) / `MRC_CLK_NS)
`define MRC_TMOD_CYC     ((`MRC_TMOD_NCK > `MRC_TMOD_CYC_NS) ? `MRC_TMOD_NCK : `MRC_TMOD_CYC_NS)
`define MRC_BL_LSB       0
`define MRC_BT_BIT       3
`define MRC_TM_BIT       7
`define MRC_DLLR_BIT     8
`define MRC_WR_LSB       9
`define MRC_PPD_BIT      12
`define MRC_BCN_BIT      12
`define MRC_BL_FIX8      2'h0
`define MRC_BL_OTF       2'h1
`define MRC_BL_FIX4      2'h2
`define MRC_CL_BASE      5'h04
`define MRC_EARLY_CYC    2
`define MRC_CHOP_DRIVE   8'h0F
`define MRC_FULL_DRIVE   8'hFF
`endif

// ==== common/mrc_pkg.sv ====
// Purpose: Types shared by the operating-mode register block.
// Assumes: Nothing beyond the command truth table.
// Notes:   Command kinds decoded from CS#, RAS#, CAS#, WE#.
package mrc_pkg;
  typedef enum logic [2:0] {
    CmdDes,
    CmdNop,
    CmdMrs,
    CmdRead,
    CmdWrite,
    CmdOther
  } mrc_cmd_t;
endpackage : mrc_pkg

// ==== src/mrc_mode_reg.sv ====
// Purpose: Operating-mode register, command spacing and burst ordering.
// Assumes: Command pins are synchronous to sys_clk; AL and tRP come from outside.
// Notes:   The register cannot be read back; its fields appear as outputs.
`timescale 1ns/1ns
`include "mrc_cfg.svh"
module mrc_mode_reg (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        cke,
  input  wire logic        csN,
  input  wire logic        rasN,
  input  wire logic        casN,
  input  wire logic        weN,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic [4:0]  alCycles,
  input  wire logic [4:0]  trpCycles,
  output logic [1:0]       burstModeQ,
  output logic             interleaveQ,
  output logic [4:0]       casLatencyQ,
  output logic             testModeQ,
  output logic [4:0]       writeRecovQ,
  output logic             pdFastExitQ,
  output logic [5:0]       readLatencyQ,
  output logic [5:0]       dalCyclesQ,
  output logic             dllResetStartQ,
  output logic             modBusyQ,
  output logic             mrdViolationQ,
  output logic             modViolationQ,
  output logic             burstValidQ,
  output logic             burstIsWriteQ,
  output logic             burstChopQ,
  output logic             writeEarlyQ,
  output logic [23:0]      beatOrderQ,
  output logic [7:0]       beatDriveQ
);

  mrc_pkg::mrc_cmd_t cmd;
  logic [15:0] opModeQ;
  logic [3:0]  mrdCntQ;
  logic [4:0]  modCntQ;
  logic [4:0]  modCntD;
  logic [4:0]  sinceMrsQ;
  logic        mrsHit;
  logic        isChop;
  logic [23:0] orderD;

  // Sequential rotates inside each half; interleaved is a plain XOR.
  function automatic logic [2:0] beatAt(
    input logic [2:0] start,
    input logic [2:0] idx,
    input logic       ilv
  );
    logic [1:0] low;
    low = start[1:0] + idx[1:0];
    if (ilv) begin
      beatAt = start ^ idx;
    end else begin
      beatAt = {start[2] ^ idx[2], low};
    end
  endfunction : beatAt

  function automatic logic [4:0] wrCycles(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h10;
    unique case (code)
      3'h0: r = 5'h10;
      3'h1: r = 5'h05;
      3'h2: r = 5'h06;
      3'h3: r = 5'h07;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0A;
      3'h6: r = 5'h0C;
      3'h7: r = 5'h0E;
    endcase
    wrCycles = r;
  endfunction : wrCycles

  // Commands are only registered while CKE is high.
  always_comb begin
    cmd = mrc_pkg::CmdOther;
    if (csN || !cke) begin
      cmd = mrc_pkg::CmdDes;
    end else begin
      unique case ({rasN, casN, weN})
        3'b111: cmd = mrc_pkg::CmdNop;
        3'b000: cmd = mrc_pkg::CmdMrs;
        3'b101: cmd = mrc_pkg::CmdRead;
        3'b100: cmd = mrc_pkg::CmdWrite;
        default: cmd = mrc_pkg::CmdOther;
      endcase
    end
  end

  assign mrsHit = (cmd == mrc_pkg::CmdMrs) && (ba == 3'h0);

  // Whole word replaced on the command edge; the array is never touched.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      opModeQ <= 16'h0000;
    end else if (mrsHit) begin
      opModeQ <= addr;
    end else begin
      opModeQ[`MRC_DLLR_BIT] <= 1'b0;
    end
  end

  // Fields take effect one edge after the command, well inside tMOD.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      burstModeQ  <= `MRC_BL_FIX8;
      interleaveQ <= 1'b0;
      casLatencyQ <= `MRC_CL_BASE;
      testModeQ   <= 1'b0;
      writeRecovQ <= 5'h10;
      pdFastExitQ <= 1'b0;
    end else if (mrsHit) begin
      burstModeQ  <= addr[`MRC_BL_LSB +: 2];
      interleaveQ <= addr[`MRC_BT_BIT];
      casLatencyQ <= `MRC_CL_BASE + {addr[2], addr[6:4]};
      testModeQ   <= addr[`MRC_TM_BIT];
      writeRecovQ <= wrCycles(addr[`MRC_WR_LSB +: 3]);
      pdFastExitQ <= addr[`MRC_PPD_BIT];
    end
  end

  // DLL reset is a single start pulse; the stored bit never lingers.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dllResetStartQ <= 1'b0;
    end else begin
      dllResetStartQ <= mrsHit && addr[`MRC_DLLR_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      readLatencyQ <= 6'h00;
      dalCyclesQ   <= 6'h00;
    end else begin
      readLatencyQ <= {1'b0, alCycles} + {1'b0, casLatencyQ};
      dalCyclesQ   <= {1'b0, writeRecovQ} + {1'b0, trpCycles};
    end
  end

  // Spacing monitors; violations are sticky so a lone slip is not missed.
  assign modCntD = mrsHit ? 5'(`MRC_TMOD_CYC) :
                   (modCntQ != 5'h00) ? modCntQ - 5'h01 : 5'h00;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mrdCntQ  <= 4'h0;
      modCntQ  <= 5'h00;
      modBusyQ <= 1'b0;
    end else begin
      if (mrsHit) begin
        mrdCntQ <= 4'(`MRC_TMRD_NCK - 1);
      end else if (mrdCntQ != 4'h0) begin
        mrdCntQ <= mrdCntQ - 4'h1;
      end
      modCntQ  <= modCntD;
      modBusyQ <= modCntD != 5'h00;
    end
  end

  // Cycles since the last mode-set, saturating; a counter keeps the tMOD check cheap to unroll.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sinceMrsQ <= 5'h1F;
    end else if (mrsHit) begin
      sinceMrsQ <= 5'h00;
    end else if (sinceMrsQ != 5'h1F) begin
      sinceMrsQ <= sinceMrsQ + 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mrdViolationQ <= 1'b0;
      modViolationQ <= 1'b0;
    end else begin
      if ((cmd == mrc_pkg::CmdMrs) && (mrdCntQ != 4'h0)) begin
        mrdViolationQ <= 1'b1;
      end
      if (modBusyQ && (cmd != mrc_pkg::CmdMrs) && (cmd != mrc_pkg::CmdNop)
          && (cmd != mrc_pkg::CmdDes)) begin
        modViolationQ <= 1'b1;
      end
    end
  end

  // Chop-4 is fixed, or chosen on the fly by BC# low.
  assign isChop = (burstModeQ == `MRC_BL_FIX4) ||
                  ((burstModeQ == `MRC_BL_OTF) && !addr[`MRC_BCN_BIT]);

  always_comb begin
    orderD = 24'h000000;
    for (int i = 0; i < 8; i++) begin
      if (cmd == mrc_pkg::CmdWrite) begin
        if (isChop) begin
          orderD[3*i +: 3] = {addr[2], 2'(i)};
        end else begin
          orderD[3*i +: 3] = 3'(i);
        end
      end else begin
        orderD[3*i +: 3] = beatAt(addr[2:0], 3'(i), interleaveQ);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      burstValidQ   <= 1'b0;
      burstIsWriteQ <= 1'b0;
      burstChopQ    <= 1'b0;
      writeEarlyQ   <= 1'b0;
      beatOrderQ    <= 24'h000000;
      beatDriveQ    <= 8'h00;
    end else begin
      burstValidQ   <= (cmd == mrc_pkg::CmdRead) || (cmd == mrc_pkg::CmdWrite);
      burstIsWriteQ <= cmd == mrc_pkg::CmdWrite;
      burstChopQ    <= isChop;
      // Only a fixed chop pulls the write reference in; on-the-fly keeps BL8 timing.
      writeEarlyQ   <= (cmd == mrc_pkg::CmdWrite) && (burstModeQ == `MRC_BL_FIX4);
      beatOrderQ    <= orderD;
      if (cmd == mrc_pkg::CmdRead) begin
        beatDriveQ <= isChop ? `MRC_CHOP_DRIVE : `MRC_FULL_DRIVE;
      end else begin
        beatDriveQ <= 8'h00;
      end
    end
  end

  a_mrs_latch_fields: assert property (@(posedge sys_clk) disable iff (!rstn)
    mrsHit |=> (burstModeQ == $past(addr[1:0])) && (pdFastExitQ == $past(addr[12])))
    else $error("Mode fields not latched from address.");

  a_cas_decode: assert property (@(posedge sys_clk) disable iff (!rstn)
    mrsHit |=> casLatencyQ == 5'h04 + {$past(addr[2]), $past(addr[6:4])})
    else $error("CAS latency decode wrong.");

  a_read_latency_sum: assert property (@(posedge sys_clk) disable iff (!rstn)
    rstn |=> readLatencyQ == {1'b0, $past(alCycles)} + {1'b0, $past(casLatencyQ)})
    else $error("Read latency is not AL plus CL.");

  a_dll_pulse_once: assert property (@(posedge sys_clk) disable iff (!rstn)
    mrsHit && addr[8] |=> dllResetStartQ ##1 (!dllResetStartQ || $past(mrsHit)))
    else $error("DLL reset start not a single pulse.");

  a_dll_bit_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
    !mrsHit |=> !opModeQ[8])
    else $error("DLL reset bit did not self-clear.");

  a_mod_busy_span: assert property (@(posedge sys_clk) disable iff (!rstn)
    modBusyQ == (sinceMrsQ < 5'(`MRC_TMOD_CYC)))
    else $error("tMOD window wrong length.");

  a_mod_busy_start: assert property (@(posedge sys_clk) disable iff (!rstn)
    mrsHit |=> modBusyQ[*8])
    else $error("tMOD window ended early.");

  a_mrd_back_to_back: assert property (@(posedge sys_clk) disable iff (!rstn)
    mrsHit ##1 (cmd == mrc_pkg::CmdMrs) |=> mrdViolationQ)
    else $error("Back-to-back mode-set not flagged.");

  a_chop_read_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd == mrc_pkg::CmdRead) && isChop |=> beatDriveQ == 8'h0F)
    else $error("Chop-4 read drives released slots.");

  a_write_order_seq: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd == mrc_pkg::CmdWrite) && !isChop |=> beatOrderQ == 24'hFAC688)
    else $error("BL8 write order is not 0 to 7.");

  a_early_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd == mrc_pkg::CmdWrite) |=> writeEarlyQ == ($past(burstModeQ) == 2'h2))
    else $error("Early write reference misplaced.");

  a_ilv_first_beat: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd == mrc_pkg::CmdRead) |=> beatOrderQ[2:0] == $past(addr[2:0]))
    else $error("First read beat is not the start column.");

  a_dal_sum: assert property (@(posedge sys_clk) disable iff (!rstn)
    rstn |=> dalCyclesQ == {1'b0, $past(writeRecovQ)} + {1'b0, $past(trpCycles)})
    else $error("Auto-precharge delay is not WR plus tRP.");

  a_type_test_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    mrsHit |=> (interleaveQ == $past(addr[3])) && (testModeQ == $past(addr[7])))
    else $error("Burst type or test bit not latched.");

  a_otf_chop: assert property (@(posedge sys_clk) disable iff (!rstn)
    ((cmd == mrc_pkg::CmdRead) || (cmd == mrc_pkg::CmdWrite)) && (burstModeQ == 2'h1)
    |=> burstChopQ == !$past(addr[12]))
    else $error("On-the-fly chop does not follow BC pin.");

  a_full_read_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd == mrc_pkg::CmdRead) && !isChop |=> beatDriveQ == 8'hFF)
    else $error("Eight-beat read does not drive all slots.");

  a_chop_write_half: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cmd == mrc_pkg::CmdWrite) && isChop |=> beatOrderQ[11:0] ==
      {$past(addr[2]), 2'h3, $past(addr[2]), 2'h2, $past(addr[2]), 2'h1, $past(addr[2]), 2'h0})
    else $error("Chop-4 write half not chosen by column bit 2.");

  a_cke_low_ignored: assert property (@(posedge sys_clk) disable iff (!rstn)
    !cke |=> $stable(burstModeQ) && $stable(casLatencyQ))
    else $error("Command taken while CKE low.");

endmodule : mrc_mode_reg

// ==== bench/mrc_ctrl_model.sv ====
// Purpose: Controller model driving the command and address pins.
// Assumes: Each request starts at a rising edge and is taken at the next one.
// Notes:   Spacing is kept unless early is set, which provokes the sticky flags.
`timescale 1ns/1ns
module mrc_ctrl_model (
  input  wire logic        sys_clk,
  output logic             cke,
  output logic             csN,
  output logic             rasN,
  output logic             casN,
  output logic             weN,
  output logic [2:0]       ba,
  output logic [15:0]      addr
);
  int   cyc     = 0;
  int   lastCyc = -100;
  int   dllCyc  = -1000;
  logic lastMrs = 1'b0;
  // Lock time is a plain default; the real figure depends on the speed grade.
  localparam int TDLLK_NCK = 512;
  initial begin
    cke = 1'b1;
    {csN, rasN, casN, weN} = 4'hF;
    ba = 3'h0;
    addr = 16'h0000;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end
  // No bank is ever opened, so every mode-set finds the device idle.
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                       input bit early);
    int need;
    // A mode-set after a burst waits long enough for the longest read to drain.
    need = lastMrs ? ((c == 4'h0) ? 4 : 12) : ((c == 4'h0) ? 64 : 0);
    @(posedge sys_clk);
    while (!early && ((cyc - lastCyc < need) ||
           ((c == 4'h5) && (cyc - dllCyc < TDLLK_NCK)))) @(posedge sys_clk);
    {csN, rasN, casN, weN} <= c;
    ba <= b;
    addr <= a;
    @(posedge sys_clk);
    lastCyc = cyc;
    lastMrs = (c == 4'h0);
    if ((c == 4'h0) && (b == 3'h0) && a[8]) dllCyc = cyc;
    // Released pins show the inverse so a stale value can never pass.
    csN <= 1'b1;
    {rasN, casN, weN} <= ~c[2:0];
    ba <= ~b;
    addr <= ~a;
  endtask : issue
  task automatic setCke(input logic k);
    @(posedge sys_clk);
    cke <= k;
  endtask : setCke
endmodule : mrc_ctrl_model

// ==== bench/dram_mode_register_mr0_control_tb_top.sv ====
// Purpose: Self-checking bench for the operating-mode register block.
// Assumes: Fields answer one edge after a command, latency sums two edges after.
// Notes:   Expected values come from integer tables, never from the design.
`timescale 1ns/1ns
module dram_mode_register_mr0_control_tb_top;
  logic        sys_clk = 1'b0;
  logic        rstn;
  logic [4:0]  alCycles, trpCycles;
  logic        cke, csN, rasN, casN, weN;
  logic [2:0]  ba;
  logic [15:0] addr;
  logic [1:0]  burstModeQ;
  logic [4:0]  casLatencyQ, writeRecovQ;
  logic [5:0]  readLatencyQ, dalCyclesQ;
  logic        interleaveQ, testModeQ, pdFastExitQ, dllResetStartQ, modBusyQ;
  logic        mrdViolationQ, modViolationQ, burstValidQ, burstIsWriteQ;
  logic        burstChopQ, writeEarlyQ;
  logic [23:0] beatOrderQ, mask;
  logic [7:0]  beatDriveQ;
  logic [31:0] seed = 32'h6BF0A093;
  logic [31:0] r;
  logic [15:0] w;
  logic        wr, bc, ch;
  int          num_errors = 0;
  int          comparisons = 0;
  int          wrTab[8] = '{16, 5, 6, 7, 8, 10, 12, 14};

  always #50 sys_clk = ~sys_clk;

  mrc_ctrl_model u_mrc_ctrl_model (.sys_clk, .cke, .csN, .rasN, .casN, .weN, .ba, .addr);
  mrc_mode_reg u_mrc_mode_reg (.sys_clk, .rstn, .cke, .csN, .rasN, .casN, .weN, .ba, .addr,
    .alCycles, .trpCycles, .burstModeQ, .interleaveQ, .casLatencyQ, .testModeQ,
    .writeRecovQ, .pdFastExitQ, .readLatencyQ, .dalCyclesQ, .dllResetStartQ, .modBusyQ,
    .mrdViolationQ, .modViolationQ, .burstValidQ, .burstIsWriteQ, .burstChopQ,
    .writeEarlyQ, .beatOrderQ, .beatDriveQ);

  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [23:0] expOrder(input logic [2:0] s, input logic ilv,
                                           input logic w8, input logic c4);
    logic [23:0] o;
    logic [2:0]  i;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      if (w8) o[3*k+:3] = c4 ? {s[2], i[1:0]} : i;
      else if (ilv) o[3*k+:3] = s ^ i;
      else o[3*k+:3] = {s[2] ^ i[2], s[1:0] + i[1:0]};
    end
    return o;
  endfunction : expOrder

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    #2000000;
    num_errors++;
    results();
  end

  initial begin
    rstn = 1'b0;
    alCycles = 5'h00;
    trpCycles = 5'h00;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk(casLatencyQ, 4);
    chk(writeRecovQ, 16);
    for (int n = 0; n < 9; n++) begin
      r = rnd();
      // Every recovery code gives five cycles or more, above tWR at this clock.
      w = {3'h0, r[12:8], 1'b0, r[6:2], 2'(n % 3)};
      @(posedge sys_clk);
      alCycles <= r[20:16];
      trpCycles <= r[25:21];
      u_mrc_ctrl_model.issue(4'h0, 3'h0, w, 1'b0);
      #1;
      chk(burstModeQ, w[1:0]);
      chk(interleaveQ, w[3]);
      chk(testModeQ, w[7]);
      chk(casLatencyQ, 4 + {w[2], w[6:4]});
      chk(writeRecovQ, wrTab[w[11:9]]);
      chk(pdFastExitQ, w[12]);
      chk(dllResetStartQ, w[8]);
      chk(modBusyQ, 1);
      @(posedge sys_clk);
      #1;
      chk(dllResetStartQ, 0);
      chk(readLatencyQ, r[20:16] + 4 + {w[2], w[6:4]});
      chk(dalCyclesQ, wrTab[w[11:9]] + r[25:21]);
      repeat (10) @(posedge sys_clk);
      #1;
      chk(modBusyQ, 1);
      @(posedge sys_clk);
      #1;
      chk(modBusyQ, 0);
      for (int s = 0; s < 8; s++) begin
        r = rnd();
        wr = r[0];
        bc = r[1];
        ch = (w[1:0] == 2'h2) || (w[1:0] == 2'h1 && !bc);
        mask = ch ? 24'h000FFF : 24'hFFFFFF;
        u_mrc_ctrl_model.issue(wr ? 4'h4 : 4'h5, r[4:2], {3'h0, bc, 9'h0, 3'(s)}, 1'b0);
        #1;
        chk({burstValidQ, burstIsWriteQ, burstChopQ}, {1'b1, wr, ch});
        chk(writeEarlyQ, wr && w[1:0] == 2'h2);
        chk(beatOrderQ & mask, expOrder(3'(s), w[3], wr, ch) & mask);
        chk(beatDriveQ, wr ? 8'h00 : (ch ? 8'h0F : 8'hFF));
      end
    end
    chk({mrdViolationQ, modViolationQ}, 0);
    // Another bank address, or CKE low, must leave this register as it was.
    u_mrc_ctrl_model.issue(4'h0, 3'h1, 16'h0003, 1'b0);
    u_mrc_ctrl_model.setCke(1'b0);
    u_mrc_ctrl_model.issue(4'h0, 3'h0, 16'h0003, 1'b0);
    #1;
    chk({burstModeQ, modBusyQ}, {w[1:0], 1'b0});
    u_mrc_ctrl_model.setCke(1'b1);
    u_mrc_ctrl_model.issue(4'h0, 3'h0, 16'h0000, 1'b0);
    u_mrc_ctrl_model.issue(4'h0, 3'h0, 16'h0000, 1'b1);
    u_mrc_ctrl_model.issue(4'h5, 3'h0, 16'h0000, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(mrdViolationQ, 1);
    chk(modViolationQ, 1);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk({mrdViolationQ, modViolationQ, casLatencyQ}, 4);
    results();
  end
endmodule : dram_mode_register_mr0_control_tb_top
